// File: pkg/gpio_consts.svh
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH
`define OFF_P4_DATA   12'h0000
`define OFF_P4_DIR    12'h0004
`define OFF_P4_PU     12'h0008
`define OFF_P5_DATA   12'h000C
`define OFF_P5_DIR    12'h0010
`define OFF_P5_PU     12'h0014
`define OFF_P6_DATA   12'h0018
`define OFF_P6_DIR    12'h001C
`define OFF_P6_PU     12'h0020
`define OFF_P7_DATA   12'h0024
`define OFF_P7_DIR    12'h0028
`define OFF_P7_PU     12'h002C
`define OFF_P12_DATA  12'h0030
`define OFF_P12_DIR   12'h0034
`define OFF_P12_PU    12'h0038
`define OFF_P13_DATA  12'h003C
`define OFF_P13_DIR   12'h0040
`define OFF_P13_PU    12'h0044
`define OFF_RT_SEL    12'h0048
`define OFF_RT_BUF    12'h004C
`define OFF_EDGE_SEL  12'h0050
`define OFF_INT_STAT  12'h0054
`define OFF_INT_MASK  12'h0058
`define OFF_PIN_IN    12'h005C
`define STAT_KEY_BIT  0
`define STAT_EXT_LSB  1
`define DIR_RESET     8'hFF
`define EDGE_RESET    16'h0000
`define ZERO32        32'h0000_0000
`endif

// File: pkg/gpio_pkg.sv
package gpio_pkg;
  typedef enum logic [1:0] {
    EDGE_NONE_TYPE_V = 2'b00,
    EDGE_RISE_TYPE_V = 2'b01,
    EDGE_FALL_TYPE_V = 2'b10,
    EDGE_BOTH_TYPE_V = 2'b11
  } edge_sel_type;
endpackage

// File: rtl/edge_detect.sv
`timescale 1ns/1ns
`default_nettype none
module edge_detect #(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_sync,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  // Two flops guard against metastability; only the second one feeds logic.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      meta_q <= pin_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign pin_sync = sync_q;
  assign rise     = sync_q & ~prev_q;
  assign fall     = ~sync_q & prev_q;
endmodule
`default_nettype wire

// File: rtl/multi_port_io_pins.sv
// Overview of operation
// - The byte-wide port switches all eight pins between input and output with one direction bit.
// - Every other port has one direction bit per pin.
// - A software pull-up enable acts on a pin only while that pin is an input.
// - Any falling edge on the byte-wide port sets the falling-edge test flag.
// - The low four pins of port 6 are open drain: zero pulls low, one releases the pin.
// - When selected, port 12 pins show preloaded real-time data that updates on a trigger.
// - Each external interrupt input detects rising, falling or both edges as software selects.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_consts.svh"
module multi_port_io_pins #(
  parameter int NUM_EXT = 7
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic [7:0]  byte_wide_port_pins_in,
  output logic      [7:0]  byte_wide_port_pins_out,
  output logic      [7:0]  byte_wide_port_pins_oe,
  output logic      [7:0]  byte_wide_port_pins_pu,
  input  wire logic [7:0]  high_address_port_pins_in,
  output logic      [7:0]  high_address_port_pins_out,
  output logic      [7:0]  high_address_port_pins_oe,
  output logic      [7:0]  high_address_port_pins_pu,
  input  wire logic [7:0]  port6_pins_in,
  output logic      [7:0]  port6_pins_out,
  output logic      [7:0]  port6_pins_oe,
  output logic      [7:0]  port6_pins_pu,
  input  wire logic [2:0]  serial_shared_pins_in,
  output logic      [2:0]  serial_shared_pins_out,
  output logic      [2:0]  serial_shared_pins_oe,
  output logic      [2:0]  serial_shared_pins_pu,
  input  wire logic [7:0]  realtime_shared_pins_in,
  output logic      [7:0]  realtime_shared_pins_out,
  output logic      [7:0]  realtime_shared_pins_oe,
  output logic      [7:0]  realtime_shared_pins_pu,
  input  wire logic        realtime_trigger,
  input  wire logic [1:0]  analog_out_shared_pins_in,
  output logic      [1:0]  analog_out_shared_pins_out,
  output logic      [1:0]  analog_out_shared_pins_oe,
  output logic      [1:0]  analog_out_shared_pins_pu,
  input  wire logic [NUM_EXT-1:0] ext_interrupt_input
);
  if (NUM_EXT < 1 || NUM_EXT > 15)
  begin : g_bad_num_ext
    $error("NUM_EXT must lie between 1 and 15");
  end

  localparam int STAT_W = NUM_EXT + 1;

  logic [7:0] p4_data_q, p5_data_q, p6_data_q, p12_data_q;
  logic [2:0] p7_data_q;
  logic [1:0] p13_data_q;
  logic       p4_dir_q;
  logic [7:0] p5_dir_q, p6_dir_q, p12_dir_q;
  logic [2:0] p7_dir_q;
  logic [1:0] p13_dir_q;
  logic [7:0] p4_pu_q, p5_pu_q, p6_pu_q, p12_pu_q;
  logic [2:0] p7_pu_q;
  logic [1:0] p13_pu_q;
  logic [7:0] rt_sel_q, rt_buf_q, rt_out_q;
  logic [2*NUM_EXT-1:0] edge_sel_q;
  logic [STAT_W-1:0] stat_q, stat_d, mask_q, mask_d;
  logic [31:0] rdata_d;

  logic [7:0] p4_sync, p4_fall;
  logic [7:0] p5_sync, p6_sync, p12_sync;
  logic [2:0] p7_sync;
  logic [1:0] p13_sync;
  logic [NUM_EXT-1:0] ext_sync, ext_rise, ext_fall, ext_hit;
  logic [0:0] trig_rise;

  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && !penable && !pwrite;

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    addr_is = (a == off);
  endfunction

  edge_detect #(.WIDTH(8)) u_p4 (.pclk(pclk), .presetn(presetn), .pin_async(byte_wide_port_pins_in),
    .pin_sync(p4_sync), .rise(), .fall(p4_fall));
  edge_detect #(.WIDTH(8)) u_p5 (.pclk(pclk), .presetn(presetn), .pin_async(high_address_port_pins_in),
    .pin_sync(p5_sync), .rise(), .fall());
  edge_detect #(.WIDTH(8)) u_p6 (.pclk(pclk), .presetn(presetn), .pin_async(port6_pins_in),
    .pin_sync(p6_sync), .rise(), .fall());
  edge_detect #(.WIDTH(3)) u_p7 (.pclk(pclk), .presetn(presetn), .pin_async(serial_shared_pins_in),
    .pin_sync(p7_sync), .rise(), .fall());
  edge_detect #(.WIDTH(8)) u_p12 (.pclk(pclk), .presetn(presetn), .pin_async(realtime_shared_pins_in),
    .pin_sync(p12_sync), .rise(), .fall());
  edge_detect #(.WIDTH(2)) u_p13 (.pclk(pclk), .presetn(presetn), .pin_async(analog_out_shared_pins_in),
    .pin_sync(p13_sync), .rise(), .fall());
  edge_detect #(.WIDTH(NUM_EXT)) u_ext (.pclk(pclk), .presetn(presetn), .pin_async(ext_interrupt_input),
    .pin_sync(ext_sync), .rise(ext_rise), .fall(ext_fall));
  edge_detect #(.WIDTH(1)) u_trig (.pclk(pclk), .presetn(presetn), .pin_async(realtime_trigger),
    .pin_sync(), .rise(trig_rise), .fall());

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EXT; gi++)
    begin : g_ext
      gpio_pkg::edge_sel_type sel;
      assign sel = gpio_pkg::edge_sel_type'(edge_sel_q[2*gi +: 2]);
      assign ext_hit[gi] = (ext_rise[gi] && sel[0]) || (ext_fall[gi] && sel[1]);
    end
  endgenerate

  // Port data, direction and pull-up registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      p4_data_q  <= '0;
      p5_data_q  <= '0;
      p6_data_q  <= '0;
      p7_data_q  <= '0;
      p12_data_q <= '0;
      p13_data_q <= '0;
      p4_dir_q   <= 1'b1;
      p5_dir_q   <= `DIR_RESET;
      p6_dir_q   <= `DIR_RESET;
      p7_dir_q   <= 3'h7;
      p12_dir_q  <= `DIR_RESET;
      p13_dir_q  <= 2'h3;
      p4_pu_q    <= '0;
      p5_pu_q    <= '0;
      p6_pu_q    <= '0;
      p7_pu_q    <= '0;
      p12_pu_q   <= '0;
      p13_pu_q   <= '0;
    end
    else if (wr_en)
    begin
      if (addr_is(paddr, `OFF_P4_DATA))  p4_data_q  <= pwdata[7:0];
      if (addr_is(paddr, `OFF_P4_DIR))   p4_dir_q   <= pwdata[0];
      if (addr_is(paddr, `OFF_P4_PU))    p4_pu_q    <= pwdata[7:0];
      if (addr_is(paddr, `OFF_P5_DATA))  p5_data_q  <= pwdata[7:0];
      if (addr_is(paddr, `OFF_P5_DIR))   p5_dir_q   <= pwdata[7:0];
      if (addr_is(paddr, `OFF_P5_PU))    p5_pu_q    <= pwdata[7:0];
      if (addr_is(paddr, `OFF_P6_DATA))  p6_data_q  <= pwdata[7:0];
      if (addr_is(paddr, `OFF_P6_DIR))   p6_dir_q   <= pwdata[7:0];
      if (addr_is(paddr, `OFF_P6_PU))    p6_pu_q    <= pwdata[7:0];
      if (addr_is(paddr, `OFF_P7_DATA))  p7_data_q  <= pwdata[2:0];
      if (addr_is(paddr, `OFF_P7_DIR))   p7_dir_q   <= pwdata[2:0];
      if (addr_is(paddr, `OFF_P7_PU))    p7_pu_q    <= pwdata[2:0];
      if (addr_is(paddr, `OFF_P12_DATA)) p12_data_q <= pwdata[7:0];
      if (addr_is(paddr, `OFF_P12_DIR))  p12_dir_q  <= pwdata[7:0];
      if (addr_is(paddr, `OFF_P12_PU))   p12_pu_q   <= pwdata[7:0];
      if (addr_is(paddr, `OFF_P13_DATA)) p13_data_q <= pwdata[1:0];
      if (addr_is(paddr, `OFF_P13_DIR))  p13_dir_q  <= pwdata[1:0];
      if (addr_is(paddr, `OFF_P13_PU))   p13_pu_q   <= pwdata[1:0];
    end
  end

  // Real-time output: the buffer is copied to the pins only on a trigger rising edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rt_sel_q <= '0;
      rt_buf_q <= '0;
      rt_out_q <= '0;
    end
    else
    begin
      if (wr_en && addr_is(paddr, `OFF_RT_SEL))
        rt_sel_q <= pwdata[7:0];
      if (wr_en && addr_is(paddr, `OFF_RT_BUF))
        rt_buf_q <= pwdata[7:0];
      if (trig_rise[0])
        rt_out_q <= rt_buf_q;
    end
  end

  // Edge select, mask and sticky status; a new event wins over a write-one clear.
  always_comb
  begin
    stat_d = stat_q;
    if (wr_en && addr_is(paddr, `OFF_INT_STAT))
      stat_d = stat_q & ~pwdata[STAT_W-1:0];
    if (|p4_fall)
      stat_d[`STAT_KEY_BIT] = 1'b1;
    stat_d = stat_d | {ext_hit, 1'b0};
  end

  // The interrupt follows the mask's next value, so a mask write and irq move on the same edge.
  assign mask_d = (wr_en && addr_is(paddr, `OFF_INT_MASK)) ? pwdata[STAT_W-1:0] : mask_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      edge_sel_q <= '0;
      mask_q     <= '0;
      stat_q     <= '0;
      irq        <= 1'b0;
    end
    else
    begin
      if (wr_en && addr_is(paddr, `OFF_EDGE_SEL))
        edge_sel_q <= pwdata[2*NUM_EXT-1:0];
      mask_q <= mask_d;
      stat_q <= stat_d;
      irq    <= |(stat_d & mask_d);
    end
  end

  // Pin drivers; the pull-up only acts on pins that are inputs.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      byte_wide_port_pins_out    <= '0;
      byte_wide_port_pins_oe     <= '0;
      byte_wide_port_pins_pu     <= '0;
      high_address_port_pins_out <= '0;
      high_address_port_pins_oe  <= '0;
      high_address_port_pins_pu  <= '0;
      port6_pins_out             <= '0;
      port6_pins_oe              <= '0;
      port6_pins_pu              <= '0;
      serial_shared_pins_out     <= '0;
      serial_shared_pins_oe      <= '0;
      serial_shared_pins_pu      <= '0;
      realtime_shared_pins_out   <= '0;
      realtime_shared_pins_oe    <= '0;
      realtime_shared_pins_pu    <= '0;
      analog_out_shared_pins_out <= '0;
      analog_out_shared_pins_oe  <= '0;
      analog_out_shared_pins_pu  <= '0;
    end
    else
    begin
      byte_wide_port_pins_out    <= p4_data_q;
      byte_wide_port_pins_oe     <= {8{~p4_dir_q}};
      byte_wide_port_pins_pu     <= p4_pu_q & {8{p4_dir_q}};
      high_address_port_pins_out <= p5_data_q;
      high_address_port_pins_oe  <= ~p5_dir_q;
      high_address_port_pins_pu  <= p5_pu_q & p5_dir_q;
      // Open drain low nibble drives a constant zero, enabled only when the latch is zero.
      port6_pins_out             <= {p6_data_q[7:4], 4'h0};
      port6_pins_oe              <= {~p6_dir_q[7:4], ~p6_dir_q[3:0] & ~p6_data_q[3:0]};
      port6_pins_pu              <= {p6_pu_q[7:4] & p6_dir_q[7:4], 4'h0};
      serial_shared_pins_out     <= p7_data_q;
      serial_shared_pins_oe      <= ~p7_dir_q;
      serial_shared_pins_pu      <= p7_pu_q & p7_dir_q;
      realtime_shared_pins_out   <= (rt_sel_q & rt_out_q) | (~rt_sel_q & p12_data_q);
      realtime_shared_pins_oe    <= rt_sel_q | ~p12_dir_q;
      realtime_shared_pins_pu    <= p12_pu_q & p12_dir_q & ~rt_sel_q;
      analog_out_shared_pins_out <= p13_data_q;
      analog_out_shared_pins_oe  <= ~p13_dir_q;
      analog_out_shared_pins_pu  <= p13_pu_q & p13_dir_q;
    end
  end

  // Read mux; reads of a port data address return the pin level.
  always_comb
  begin
    rdata_d = `ZERO32;
    case (paddr)
      `OFF_P4_DATA:   rdata_d[7:0] = p4_sync;
      `OFF_P4_DIR:    rdata_d[0] = p4_dir_q;
      `OFF_P4_PU:     rdata_d[7:0] = p4_pu_q;
      `OFF_P5_DATA:   rdata_d[7:0] = p5_sync;
      `OFF_P5_DIR:    rdata_d[7:0] = p5_dir_q;
      `OFF_P5_PU:     rdata_d[7:0] = p5_pu_q;
      `OFF_P6_DATA:   rdata_d[7:0] = p6_sync;
      `OFF_P6_DIR:    rdata_d[7:0] = p6_dir_q;
      `OFF_P6_PU:     rdata_d[7:0] = p6_pu_q;
      `OFF_P7_DATA:   rdata_d[2:0] = p7_sync;
      `OFF_P7_DIR:    rdata_d[2:0] = p7_dir_q;
      `OFF_P7_PU:     rdata_d[2:0] = p7_pu_q;
      `OFF_P12_DATA:  rdata_d[7:0] = p12_sync;
      `OFF_P12_DIR:   rdata_d[7:0] = p12_dir_q;
      `OFF_P12_PU:    rdata_d[7:0] = p12_pu_q;
      `OFF_P13_DATA:  rdata_d[1:0] = p13_sync;
      `OFF_P13_DIR:   rdata_d[1:0] = p13_dir_q;
      `OFF_P13_PU:    rdata_d[1:0] = p13_pu_q;
      `OFF_RT_SEL:    rdata_d[7:0] = rt_sel_q;
      `OFF_RT_BUF:    rdata_d[7:0] = rt_buf_q;
      `OFF_EDGE_SEL:  rdata_d[2*NUM_EXT-1:0] = edge_sel_q;
      `OFF_INT_STAT:  rdata_d[STAT_W-1:0] = stat_q;
      `OFF_INT_MASK:  rdata_d[STAT_W-1:0] = mask_q;
      `OFF_PIN_IN:    rdata_d[NUM_EXT-1:0] = ext_sync;
      default:        rdata_d = `ZERO32;
    endcase
  end

  // Read data is captured in setup so every output stays a flop; each access takes two cycles.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= `ZERO32;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      if (rd_en)
        prdata <= rdata_d;
      pready  <= psel && !penable;
      pslverr <= 1'b0;
    end
  end

  a_byte_dir_whole: assert property (@(posedge pclk) disable iff (!presetn)
    (byte_wide_port_pins_oe == 8'h00) || (byte_wide_port_pins_oe == 8'hFF))
    else $error("byte port direction split");
  a_pullup_input: assert property (@(posedge pclk) disable iff (!presetn)
    (high_address_port_pins_pu & high_address_port_pins_oe) == 8'h00)
    else $error("pull-up on output pin");
  a_fall_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    |p4_fall |=> stat_q[`STAT_KEY_BIT])
    else $error("falling edge lost");
  a_open_drain_low: assert property (@(posedge pclk) disable iff (!presetn)
    (port6_pins_out[3:0] == 4'h0) && ((port6_pins_oe[3:0] & $past(p6_data_q[3:0])) == 4'h0))
    else $error("open drain drives high");
  a_rt_update: assert property (@(posedge pclk) disable iff (!presetn)
    trig_rise[0] |=> rt_out_q == $past(rt_buf_q))
    else $error("real-time output not loaded");
  a_rt_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !trig_rise[0] |=> $stable(rt_out_q))
    else $error("real-time output moved without trigger");
  a_ext_edge: assert property (@(posedge pclk) disable iff (!presetn)
    ext_rise[0] && edge_sel_q[0] |=> stat_q[`STAT_EXT_LSB])
    else $error("external edge lost");
  a_dir_per_pin: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> high_address_port_pins_oe == ~$past(p5_dir_q))
    else $error("port direction wrong");
  a_reset_input: assert property (@(posedge pclk)
    !presetn |-> (byte_wide_port_pins_oe == 8'h00) && (realtime_shared_pins_oe == 8'h00))
    else $error("driver on during reset");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> irq == |(stat_q & mask_q))
    else $error("interrupt level wrong");

  c_key_flag: cover property (@(posedge pclk) disable iff (!presetn) |p4_fall);
  c_rt_trigger: cover property (@(posedge pclk) disable iff (!presetn) trig_rise[0] && |rt_sel_q);
  c_ext_both: cover property (@(posedge pclk) disable iff (!presetn) ext_fall[0] && edge_sel_q[1:0] == 2'b11);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule
`default_nettype wire

// File: test/pin_board.sv
`timescale 1ns/1ns
`default_nettype none
// Board side of one port: a pin follows its driver, then an external source, then the pull-up.
// A pin nobody drives shows the inverse of the port value, so a stale level never reads as a match.
module pin_board #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] pu,
  input  wire logic [W-1:0] ext_en,
  input  wire logic [W-1:0] ext_val,
  output logic      [W-1:0] pins
);
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      pins[i] = oe[i] ? out[i] : ext_en[i] ? ext_val[i] : pu[i] ? 1'b1 : ~out[i];
    end
  end
endmodule
`default_nettype wire

// File: test/test_multi_port_io_pins.sv
`timescale 1ns/1ns
`default_nettype none
`include "gpio_consts.svh"
module test_multi_port_io_pins;
  logic        pclk, presetn, psel, penable, pwrite, irq, pready, pslverr, trig;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  b_in, b_out, b_oe, b_pu, b_en, b_val, h_in, h_out, h_oe, h_pu;
  logic [7:0]  s_in, s_out, s_oe, s_pu, r_in, r_out, r_oe, r_pu;
  logic [2:0]  t_in, t_out, t_oe, t_pu;
  logic [1:0]  a_in, a_out, a_oe, a_pu;
  logic [6:0]  ext;
  logic [7:0]  h_en, h_val, s_en, s_val, r_en, r_val;
  logic [2:0]  t_en, t_val;
  logic [1:0]  a_en, a_val;
  int          miscompares, n_compared;

  multi_port_io_pins multi_port_io_pins_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .byte_wide_port_pins_in(b_in), .byte_wide_port_pins_out(b_out), .byte_wide_port_pins_oe(b_oe),
    .byte_wide_port_pins_pu(b_pu), .high_address_port_pins_in(h_in), .high_address_port_pins_out(h_out),
    .high_address_port_pins_oe(h_oe), .high_address_port_pins_pu(h_pu), .port6_pins_in(s_in),
    .port6_pins_out(s_out), .port6_pins_oe(s_oe), .port6_pins_pu(s_pu), .serial_shared_pins_in(t_in),
    .serial_shared_pins_out(t_out), .serial_shared_pins_oe(t_oe), .serial_shared_pins_pu(t_pu),
    .realtime_shared_pins_in(r_in), .realtime_shared_pins_out(r_out), .realtime_shared_pins_oe(r_oe),
    .realtime_shared_pins_pu(r_pu), .realtime_trigger(trig), .analog_out_shared_pins_in(a_in),
    .analog_out_shared_pins_out(a_out), .analog_out_shared_pins_oe(a_oe), .analog_out_shared_pins_pu(a_pu),
    .ext_interrupt_input(ext));
  pin_board #(.W(8)) pb_b (.out(b_out), .oe(b_oe), .pu(b_pu), .ext_en(b_en), .ext_val(b_val), .pins(b_in));
  pin_board #(.W(8)) pb_h (.out(h_out), .oe(h_oe), .pu(h_pu), .ext_en(h_en), .ext_val(h_val), .pins(h_in));
  pin_board #(.W(8)) pb_s (.out(s_out), .oe(s_oe), .pu(s_pu), .ext_en(s_en), .ext_val(s_val), .pins(s_in));
  pin_board #(.W(3)) pb_t (.out(t_out), .oe(t_oe), .pu(t_pu), .ext_en(t_en), .ext_val(t_val), .pins(t_in));
  pin_board #(.W(8)) pb_r (.out(r_out), .oe(r_oe), .pu(r_pu), .ext_en(r_en), .ext_val(r_val), .pins(r_in));
  pin_board #(.W(2)) pb_a (.out(a_out), .oe(a_oe), .pu(a_pu), .ext_en(a_en), .ext_val(a_val), .pins(a_in));

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Holds the request until pready is sampled high; the bound only guards against a hang.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && i < 50)
    begin
      @(posedge pclk);
      i++;
    end
    q = prdata;
    check("pslverr", pslverr, 32'h0000_0000);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      miscompares++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, trig} = 5'h10;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    b_en = 8'h00;
    b_val = 8'h00;
    {h_en, h_val, s_en, s_val, r_en, r_val} = 48'h0000_0000_0000;
    {t_en, t_val, a_en, a_val} = 10'h000;
    ext = 7'h00;
    miscompares = 0;
    n_compared = 0;
    // Reset falls after time zero so the design surely sees the edge.
    #1 presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    check("oe after reset", {b_oe, h_oe, s_oe, r_oe}, 32'h0000_0000);
    check("pu after reset", {b_pu, h_pu, s_pu, r_pu}, 32'h0000_0000);
    check("small oe after reset", {t_oe, a_oe, t_pu, a_pu}, 32'h0000_0000);
    apb(1'b0, `OFF_P5_DIR, 32'h0, rd);
    check("p5 dir reset", rd, 32'h0000_00FF);
    wr(`OFF_P4_DATA, 32'h0000_00A5);
    wr(`OFF_P4_PU, 32'h0000_00FF);
    settle();
    check("byte pu as input", b_pu, 32'h0000_00FF);
    wr(`OFF_P4_DIR, 32'h0000_00FE);
    settle();
    check("byte oe", b_oe, 32'h0000_00FF);
    check("byte out", b_out, 32'h0000_00A5);
    check("byte pu as output", b_pu, 32'h0000_0000);
    wr(`OFF_P4_DIR, 32'h0000_0001);
    wr(`OFF_P5_DATA, 32'h0000_003C);
    wr(`OFF_P5_DIR, 32'h0000_00A5);
    wr(`OFF_P5_PU, 32'h0000_00FF);
    wr(`OFF_P7_DIR, 32'h0000_0005);
    wr(`OFF_P13_DIR, 32'h0000_0002);
    settle();
    check("byte oe released", b_oe, 32'h0000_0000);
    check("p5 oe", h_oe, 32'h0000_005A);
    check("p5 driven value", h_out & h_oe, 32'h0000_0018);
    check("p5 pu", h_pu, 32'h0000_00A5);
    check("p7 and p13 oe", {t_oe, a_oe}, 32'h0000_0009);
    h_en <= 8'hA5;
    h_val <= 8'h21;
    t_en <= 3'h7;
    a_en <= 2'h3;
    wr(`OFF_P7_DATA, 32'h0000_0007);
    wr(`OFF_P13_DATA, 32'h0000_0003);
    settle();
    check("p7 and p13 out", {t_out & t_oe, a_out & a_oe}, 32'h0000_0009);
    apb(1'b0, `OFF_P5_DATA, 32'h0, rd);
    check("p5 pins", rd, 32'h0000_0039);
    apb(1'b0, `OFF_P7_DATA, 32'h0, rd);
    check("p7 pins", rd, 32'h0000_0002);
    wr(`OFF_P6_DATA, 32'h0000_00F5);
    wr(`OFF_P6_DIR, 32'h0000_0000);
    settle();
    check("p6 oe", s_oe, 32'h0000_00FA);
    check("p6 out", s_out, 32'h0000_00F0);
    s_en <= 8'h0F;
    s_val <= 8'h0F;
    settle();
    apb(1'b0, `OFF_P6_DATA, 32'h0, rd);
    check("p6 pins", rd, 32'h0000_00F5);
    wr(`OFF_P6_DIR, 32'h0000_00FF);
    wr(`OFF_P6_PU, 32'h0000_00FF);
    settle();
    check("p6 pu", s_pu, 32'h0000_00F0);
    b_en <= 8'hFF;
    b_val <= 8'hFF;
    settle();
    wr(`OFF_INT_STAT, 32'hFFFF_FFFF);
    wr(`OFF_INT_MASK, 32'h0000_0001);
    settle();
    check("irq idle", irq, 32'h0000_0000);
    b_val <= 8'hFB;
    settle();
    check("irq on falling edge", irq, 32'h0000_0001);
    apb(1'b0, `OFF_INT_STAT, 32'h0, rd);
    check("test flag", rd, 32'h0000_0001);
    wr(`OFF_INT_STAT, 32'h0000_0001);
    b_val <= 8'hFF;
    settle();
    check("irq cleared", irq, 32'h0000_0000);
    wr(`OFF_INT_MASK, 32'h0000_0000);
    for (int m = 0; m < 4; m++)
    begin
      wr(`OFF_EDGE_SEL, m);
      wr(`OFF_INT_STAT, 32'hFFFF_FFFF);
      ext[0] <= 1'b1;
      settle();
      apb(1'b0, `OFF_INT_STAT, 32'h0, rd);
      check("ext rise", rd[1], m % 2);
      wr(`OFF_INT_STAT, 32'hFFFF_FFFF);
      ext[0] <= 1'b0;
      settle();
      apb(1'b0, `OFF_INT_STAT, 32'h0, rd);
      check("ext fall", rd[1], m / 2);
    end
    wr(`OFF_INT_STAT, 32'hFFFF_FFFF);
    wr(`OFF_INT_MASK, 32'h0000_0002);
    ext[0] <= 1'b1;
    settle();
    check("ext irq", irq, 32'h0000_0001);
    apb(1'b0, `OFF_PIN_IN, 32'h0, rd);
    check("ext pin level", rd, 32'h0000_0001);
    wr(`OFF_P12_DATA, 32'h0000_0030);
    wr(`OFF_P12_DIR, 32'h0000_000F);
    wr(`OFF_RT_SEL, 32'h0000_000F);
    wr(`OFF_RT_BUF, 32'h0000_005A);
    trig <= 1'b1;
    settle();
    check("rt out", r_out, 32'h0000_003A);
    check("rt oe", r_oe, 32'h0000_00FF);
    r_en <= 8'hFF;
    wr(`OFF_P12_PU, 32'h0000_00FF);
    settle();
    check("rt pu off", r_pu, 32'h0000_0000);
    apb(1'b0, `OFF_P12_DATA, 32'h0, rd);
    check("rt pins", rd, 32'h0000_003A);
    wr(`OFF_RT_BUF, 32'h0000_0055);
    settle();
    check("rt holds until trigger", r_out, 32'h0000_003A);
    trig <= 1'b0;
    settle();
    trig <= 1'b1;
    settle();
    check("rt after trigger", r_out, 32'h0000_0035);
    wr(12'h0F0, 32'hFFFF_FFFF);
    apb(1'b0, 12'h0F0, 32'h0, rd);
    check("unmapped read", rd, 32'h0000_0000);
    stop_test();
  end
endmodule
`default_nettype wire
